// ==== rtl/io_pad_cell.sv ====
// programmable pad cell: input/output registers, preset, soft start, pulls
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "io_pad_defs.svh"

module io_pad_cell
  import io_pad_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // register bus
  input wire apb_req_t i_apb,
  output var apb_rsp_t o_apb,
  // user logic side
  input wire logic i_global_preset_pulse,
  input wire logic i_shared_clock_enable,
  input wire logic i_input_reg_clock,
  input wire logic i_output_reg_clock,
  input wire logic i_out_data,
  input wire logic i_out_disable,
  output var logic o_in_direct,
  output var logic o_in_reg_q,
  // package pin
  input wire logic i_pad,
  output var pad_drv_t o_pad
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [`CFG_W-1:0] cfg_w;
    phase_t phase;
    logic [3:0] soft_cnt;
    logic in_q;
    logic out_q;
    logic ick_prev;
    logic ock_prev;
    logic in_direct;
    pad_drv_t pad;
    apb_rsp_t rsp;
  } cell_st_t;

  cell_st_t st;
  cell_st_t next_st;
  cfg_t cfg;
  logic [`SYNC_W-1:0] sync_lvl;
  logic pad_lvl;
  logic ick;
  logic ock;
  logic preset_now;
  logic in_ce;
  logic out_ce;
  logic in_eff;
  logic in_rise;
  logic out_rise;
  logic out_d;
  logic setup;
  logic wr;

  ////////////////////////////////////////////////////////////////////////
  // functions

  function automatic cfg_t decode_cfg(input logic [`CFG_W-1:0] w);
    cfg_t c;
    c.in_init_set = w[`CFG_IN_INIT];
    c.out_init_set = w[`CFG_OUT_INIT];
    c.in_clk_inv = w[`CFG_IN_CKINV];
    c.out_clk_inv = w[`CFG_OUT_CKINV];
    c.ce_sel = w[`CFG_CE_HI:`CFG_CE_LO];
    c.in_latch = w[`CFG_IN_LATCH];
    c.out_reg_used = w[`CFG_OUT_REG];
    c.out_inv = w[`CFG_OUT_INV];
    c.tri_inv = w[`CFG_TRI_INV];
    c.fast_slew = w[`CFG_FAST];
    c.pad_used = w[`CFG_USED];
    c.unused_mode = w[`CFG_UNUSED_HI:`CFG_UNUSED_LO];
    return c;
  endfunction

  // steering code 3 is treated as both, so no code leaves a register dead
  function automatic logic ce_reaches(input logic [1:0] sel,
                                      input logic [1:0] mine);
    return (sel == mine) || (sel == `CE_BOTH) || (sel == 2'h3);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == `REG_CFG) || (a == `REG_STATUS) || (a == `REG_CTRL);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin side synchronisation

  // every cell has its own pair of clock inputs and its own filter
  io_sync3 u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async({i_pad, i_input_reg_clock, i_output_reg_clock}),
    .o_level(sync_lvl)
  );

  assign pad_lvl = sync_lvl[2];
  assign ick = sync_lvl[1];
  assign ock = sync_lvl[0];

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    cfg = decode_cfg(st.cfg_w);
    setup = i_apb.psel & ~i_apb.penable;
    wr = i_apb.psel & i_apb.penable & st.rsp.pready & i_apb.pwrite;

    // preset is the only set/clear path besides i_rst, which clears both to 0; configuration holds it too
    preset_now = i_global_preset_pulse | (st.phase == PH_CONFIG);

    // enable is used as is, active high, no inversion option
    // a register the enable is not steered to runs on every clock edge
    in_ce = i_shared_clock_enable | ~ce_reaches(cfg.ce_sel, `CE_IN);
    out_ce = i_shared_clock_enable | ~ce_reaches(cfg.ce_sel, `CE_OUT);

    // previous raw level kept, so flipping the inversion makes no edge
    in_eff = ick ^ cfg.in_clk_inv;
    in_rise = in_eff & ~(st.ick_prev ^ cfg.in_clk_inv);
    out_rise = (ock ^ cfg.out_clk_inv) & ~(st.ock_prev ^ cfg.out_clk_inv);
    out_d = i_out_data ^ cfg.out_inv;

    next_st.ick_prev = ick;
    next_st.ock_prev = ock;
    next_st.in_direct = pad_lvl;

    // registers: preset wins over clock and enable
    if (preset_now) begin
      next_st.in_q = cfg.in_init_set;
      next_st.out_q = cfg.out_init_set;
    end else begin
      if (cfg.in_latch) begin
        // latch is open while the effective clock is low
        if (in_ce && !in_eff) begin
          next_st.in_q = pad_lvl;
        end
      end else if (in_ce && in_rise) begin
        next_st.in_q = pad_lvl;
      end
      if (out_ce && out_rise) begin
        next_st.out_q = out_d;
      end
    end

    // startup sequence
    case (st.phase)
      PH_CONFIG: begin
        if (wr && i_apb.paddr == `REG_CTRL &&
            i_apb.pwdata[`CTRL_DONE]) begin
          next_st.phase = PH_SOFT;
          next_st.soft_cnt = 4'(`SOFT_START_CYC);
        end
      end
      PH_SOFT: begin
        if (st.soft_cnt == 4'h1) begin
          next_st.phase = PH_RUN;
        end else begin
          next_st.soft_cnt = st.soft_cnt - 4'h1;
        end
      end
      PH_RUN: begin
        next_st.phase = PH_RUN;
      end
      default: begin
        next_st.phase = PH_CONFIG;
      end
    endcase

    // pad drive
    next_st.pad = '0;
    // slow edges until the soft start window is over
    next_st.pad.slew_fast = (st.phase == PH_RUN) & cfg.fast_slew;
    if (cfg.pad_used) begin
      next_st.pad.out = cfg.out_reg_used ? st.out_q : out_d;
      next_st.pad.oe = (st.phase != PH_CONFIG) &
                       ~(i_out_disable ^ cfg.tri_inv);
    end else begin
      case (cfg.unused_mode)
        `UNUSED_PULLUP: next_st.pad.pull_up = 1'b1;
        `UNUSED_PULLDOWN: next_st.pad.pull_down = 1'b1;
        `UNUSED_DRIVEN: next_st.pad.oe = (st.phase != PH_CONFIG);
        default: next_st.pad.oe = 1'b0;
      endcase
    end

    // register bus: answer registered in setup, ready in the access cycle
    next_st.rsp.pready = setup;
    next_st.rsp.pslverr = setup & ~is_mapped(i_apb.paddr);
    next_st.rsp.prdata = '0;
    if (setup && !i_apb.pwrite) begin
      case (i_apb.paddr)
        `REG_CFG: next_st.rsp.prdata = {18'h0, st.cfg_w};
        `REG_STATUS: next_st.rsp.prdata = {24'h0, st.phase, st.pad.oe,
                       st.pad.slew_fast, st.in_direct, st.out_q, st.in_q};
        `REG_CTRL: next_st.rsp.prdata = {31'h0, st.phase != PH_CONFIG};
        default: next_st.rsp.prdata = '0;
      endcase
    end
    if (wr && i_apb.paddr == `REG_CFG) begin
      next_st.cfg_w = i_apb.pwdata[`CFG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.cfg_w <= `CFG_RESET;
      st.phase <= PH_CONFIG;
    end else begin
      st <= next_st;
    end
  end

  assign o_apb = st.rsp;
  assign o_pad = st.pad;
  assign o_in_direct = st.in_direct;
  assign o_in_reg_q = st.in_q;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  sequence soft_entry;
    $rose(st.phase == PH_SOFT);
  endsequence

  sequence soft_hold;
    (st.phase == PH_SOFT && !st.pad.slew_fast)[*8];
  endsequence

  preset_input_a: assert property (
    i_global_preset_pulse |=> st.in_q == $past(cfg.in_init_set))
    else $error("input register missed preset level");

  preset_output_a: assert property (
    i_global_preset_pulse |=> st.out_q == $past(cfg.out_init_set))
    else $error("output register missed preset level");

  enable_hold_a: assert property (
    !preset_now && !in_ce |=> st.in_q == $past(st.in_q))
    else $error("input register moved without enable");

  output_capture_a: assert property (
    !preset_now && out_ce && out_rise |=> st.out_q == $past(out_d))
    else $error("output register missed its edge");

  soft_start_a: assert property (
    soft_entry |-> soft_hold ##3 (st.phase == PH_RUN))
    else $error("soft start window wrong length");

  run_slew_a: assert property (
    st.phase == PH_RUN |=> st.pad.slew_fast == $past(cfg.fast_slew))
    else $error("run slew does not follow configuration");

  unused_pull_a: assert property (
    !cfg.pad_used && cfg.unused_mode == `UNUSED_PULLUP
    |=> st.pad.pull_up && !st.pad.oe)
    else $error("unused pad not pulled up");

  disable_hiz_a: assert property (
    cfg.pad_used && (i_out_disable ^ cfg.tri_inv) |=> !st.pad.oe)
    else $error("driver enabled while disabled");

  latch_open_a: assert property (
    !preset_now && cfg.in_latch && in_ce && !in_eff
    |=> st.in_q == $past(pad_lvl))
    else $error("open latch did not pass the pad");

  sequence preset_held;
    i_global_preset_pulse ##1 i_global_preset_pulse;
  endsequence

  output_hold_a: assert property (
    !preset_now && !out_ce |=> st.out_q == $past(st.out_q))
    else $error("output register moved without enable");

  input_capture_a: assert property (
    !preset_now && !cfg.in_latch && in_ce && in_rise
    |=> st.in_q == $past(pad_lvl))
    else $error("input register missed its edge");

  latch_hold_a: assert property (
    !preset_now && cfg.in_latch && in_eff |=> st.in_q == $past(st.in_q))
    else $error("closed latch let the pad through");

  config_force_a: assert property (
    st.phase == PH_CONFIG |=> st.in_q == $past(cfg.in_init_set) &&
    st.out_q == $past(cfg.out_init_set))
    else $error("register left its initial level in configuration");

  steer_input_a: assert property (
    !preset_now && cfg.ce_sel == `CE_IN && out_rise
    |=> st.out_q == $past(out_d))
    else $error("output register gated although steered away");

  enable_high_a: assert property (
    !preset_now && i_shared_clock_enable && out_rise
    |=> st.out_q == $past(out_d))
    else $error("high enable did not let the edge through");

  preset_override_a: assert property (
    preset_held |-> st.in_q == $past(cfg.in_init_set) &&
    st.out_q == $past(cfg.out_init_set))
    else $error("register escaped a held preset");

  unused_down_a: assert property (
    !cfg.pad_used && cfg.unused_mode == `UNUSED_PULLDOWN
    |=> st.pad.pull_down && !st.pad.pull_up && !st.pad.oe)
    else $error("unused pad not pulled down");

  soft_slew_a: assert property (
    st.phase != PH_RUN |=> !st.pad.slew_fast)
    else $error("fast slew before soft start ended");

  config_quiet_a: assert property (
    st.phase == PH_CONFIG |=> !st.pad.oe)
    else $error("pad driven during configuration");

  cfg_write_a: assert property (
    wr && i_apb.paddr == `REG_CFG
    |=> st.cfg_w == $past(i_apb.pwdata[`CFG_W-1:0]))
    else $error("configuration write lost");

endmodule
`default_nettype wire

// ==== pkg/io_pad_defs.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef IO_PAD_DEFS_SVH
`define IO_PAD_DEFS_SVH

// register byte offsets
`define REG_CFG 8'h00
`define REG_STATUS 8'h04
`define REG_CTRL 8'h08

// configuration word field positions
`define CFG_IN_INIT 0
`define CFG_OUT_INIT 1
`define CFG_IN_CKINV 2
`define CFG_OUT_CKINV 3
`define CFG_CE_LO 4
`define CFG_CE_HI 5
`define CFG_IN_LATCH 6
`define CFG_OUT_REG 7
`define CFG_OUT_INV 8
`define CFG_TRI_INV 9
`define CFG_FAST 10
`define CFG_USED 11
`define CFG_UNUSED_LO 12
`define CFG_UNUSED_HI 13
`define CFG_W 14
`define CFG_RESET 14'h0000

// clock enable steering codes
`define CE_BOTH 2'h0
`define CE_IN 2'h1
`define CE_OUT 2'h2

// unused pad modes
`define UNUSED_PULLUP 2'h0
`define UNUSED_PULLDOWN 2'h1
`define UNUSED_DRIVEN 2'h2

// control word
`define CTRL_DONE 0

// synchroniser width and soft start timing
`define SYNC_W 3
`define CLK_PERIOD_NS 100
`define SOFT_START_NS 1000
`define SOFT_START_CYC \
  ((`SOFT_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== pkg/io_pad_pkg.sv ====
// types shared by the pad cell and its synchroniser
package io_pad_pkg;

  typedef enum logic [2:0] {
    PH_CONFIG = 3'b001,
    PH_SOFT = 3'b010,
    PH_RUN = 3'b100
  } phase_t;

  typedef struct packed {
    logic [1:0] unused_mode;
    logic pad_used;
    logic fast_slew;
    logic tri_inv;
    logic out_inv;
    logic out_reg_used;
    logic in_latch;
    logic [1:0] ce_sel;
    logic out_clk_inv;
    logic in_clk_inv;
    logic out_init_set;
    logic in_init_set;
  } cfg_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_down;
    logic slew_fast;
  } pad_drv_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] lvl;
  } sync_st_t;

endpackage

// ==== rtl/io_sync3.sv ====
// three-stage synchroniser with agreement filter for pin-side inputs
`timescale 1ns/1ns
`default_nettype none
`include "io_pad_defs.svh"

module io_sync3
  import io_pad_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // asynchronous inputs and filtered levels
  input wire logic [`SYNC_W-1:0] i_async,
  output var logic [`SYNC_W-1:0] o_level
);

  sync_st_t st;
  sync_st_t next_st;

  // s1 feeds only s2; a level moves once s2 and s3 agree
  always_comb begin
    next_st = st;
    next_st.s1 = i_async;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.lvl = (st.lvl & (st.s2 ^ st.s3)) | (st.s2 & ~(st.s2 ^ st.s3));
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_level = st.lvl;

endmodule
`default_nettype wire

// ==== bench/pin_model.sv ====
// board-side model of the signal on the package pin
`timescale 1ns/1ns
`default_nettype none

module pin_model
  import io_pad_pkg::*;
(
  // clock and pad cell drive
  input wire logic i_clock,
  input wire pad_drv_t i_drv,
  // outside driver
  input wire logic i_ext_en,
  input wire logic i_ext_val,
  // resolved pin level
  output var logic o_pin
);
  logic toggle = 1'b0;

  // a floating pin wanders, so a stale level never passes unseen
  always @(posedge i_clock) begin
    toggle <= ~toggle;
  end

  always_comb begin
    if (i_drv.oe) begin
      o_pin = i_drv.out;
    end else if (i_ext_en) begin
      o_pin = i_ext_val;
    end else if (i_drv.pull_up) begin
      o_pin = 1'b1;
    end else if (i_drv.pull_down) begin
      o_pin = 1'b0;
    end else begin
      o_pin = toggle;
    end
  end
endmodule
`default_nettype wire

// ==== bench/io_pad_register_control_test.sv ====
// self-checking bench for the programmable pad cell
`timescale 1ns/1ns
`default_nettype none
`include "io_pad_defs.svh"

module io_pad_register_control_test
  import io_pad_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic preset = 1'b0;
  logic ce = 1'b1;
  logic ick = 1'b0;
  logic ock = 1'b0;
  logic od = 1'b0;
  logic odis = 1'b0;
  logic ext_en = 1'b0;
  logic ext_val = 1'b0;
  logic in_direct;
  logic in_q;
  logic pin;
  pad_drv_t drv;
  logic [31:0] rdata;
  logic rerr;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;

  always #50 clock = ~clock;

  io_pad_cell i_io_pad_cell (
    .i_clock(clock),
    .i_rst(rst),
    .i_apb(req),
    .o_apb(rsp),
    .i_global_preset_pulse(preset),
    .i_shared_clock_enable(ce),
    .i_input_reg_clock(ick),
    .i_output_reg_clock(ock),
    .i_out_data(od),
    .i_out_disable(odis),
    .o_in_direct(in_direct),
    .o_in_reg_q(in_q),
    .i_pad(pin),
    .o_pad(drv)
  );

  pin_model i_pin_model (
    .i_clock(clock),
    .i_drv(drv),
    .i_ext_en(ext_en),
    .i_ext_val(ext_val),
    .o_pin(pin)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // one apb transfer; the wait on pready is bounded by the timeout
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clock);
    req.penable <= 1'b1;
    @(posedge clock);
    while (rsp.pready !== 1'b1) begin
      @(posedge clock);
    end
    rdata = rsp.prdata;
    rerr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic status(input logic [7:0] mask, input logic [7:0] exp);
    apb(1'b0, `REG_STATUS, 32'h0);
    check({24'h0, rdata[7:0] & mask}, {24'h0, exp});
  endtask

  // clock levels held long enough for the pin synchroniser
  task automatic pulse(input logic outreg);
    if (outreg) begin
      ock <= 1'b1;
    end else begin
      ick <= 1'b1;
    end
    cyc(6);
    ock <= 1'b0;
    ick <= 1'b0;
    cyc(8);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(1'b0, `REG_CFG, 32'h0);
    check(rdata, 32'h0);
    check(drv.pull_up, 1'b1);
    status(8'he3, 8'h20);
    apb(1'b0, 8'h0c, 32'h0);
    check(rerr, 1'b1);
  endtask

  task automatic t_config();
    apb(1'b1, `REG_CFG, 32'h0000_0c81);
    status(8'h03, 8'h01);
    apb(1'b1, `REG_CTRL, 32'h0000_0001);
    status(8'he8, 8'h40);
    check(drv.slew_fast, 1'b0);
    cyc(12);
    status(8'heb, 8'h89);
    check(drv.slew_fast, 1'b1);
  endtask

  task automatic t_regs();
    od <= 1'b1;
    pulse(1'b1);
    status(8'h03, 8'h03);
    od <= 1'b0;
    pulse(1'b1);
    pulse(1'b0);
    status(8'h03, 8'h00);
    check(in_q, 1'b0);
    ce <= 1'b0;
    od <= 1'b1;
    pulse(1'b1);
    pulse(1'b0);
    status(8'h03, 8'h00);
    apb(1'b1, `REG_CFG, 32'h0000_0c91);
    pulse(1'b1);
    pulse(1'b0);
    status(8'h03, 8'h02);
    apb(1'b1, `REG_CFG, 32'h0000_0ca1);
    pulse(1'b0);
    status(8'h03, 8'h03);
    od <= 1'b0;
    pulse(1'b1);
    status(8'h03, 8'h03);
    ce <= 1'b1;
    pulse(1'b1);
    check(drv.out, 1'b0);
    od <= 1'b1;
    pulse(1'b1);
    check(drv.out, 1'b1);
  endtask

  task automatic t_preset();
    preset <= 1'b1;
    od <= 1'b0;
    pulse(1'b0);
    od <= 1'b1;
    pulse(1'b1);
    status(8'h03, 8'h01);
    preset <= 1'b0;
    cyc(2);
    status(8'h03, 8'h01);
  endtask

  task automatic t_invert();
    // data low while polarity flips, so a spurious edge captures 0
    od <= 1'b0;
    apb(1'b1, `REG_CFG, 32'h0000_0c89);
    cyc(8);
    od <= 1'b1;
    ock <= 1'b1;
    cyc(8);
    status(8'h02, 8'h00);
    ock <= 1'b0;
    cyc(8);
    status(8'h02, 8'h02);
  endtask

  task automatic t_disable();
    odis <= 1'b1;
    cyc(3);
    check(drv.oe, 1'b0);
    odis <= 1'b0;
    cyc(3);
    check(drv.oe, 1'b1);
  endtask

  task automatic t_latch();
    // open latch, inverted data and inverted disable on the direct path
    odis <= 1'b1;
    od <= 1'b0;
    apb(1'b1, `REG_CFG, 32'h0000_0b40);
    cyc(8);
    check({drv.oe, drv.out}, 2'b11);
    check(in_q, 1'b1);
    ick <= 1'b1;
    cyc(6);
    od <= 1'b1;
    cyc(8);
    check(drv.out, 1'b0);
    check(in_q, 1'b1);
    ick <= 1'b0;
    cyc(8);
    check(in_q, 1'b0);
    odis <= 1'b0;
    cyc(3);
    check(drv.oe, 1'b0);
  endtask

  task automatic t_unused();
    logic [2:0] exp [4] = '{3'b100, 3'b010, 3'b001, 3'b000};
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `REG_CFG, 32'(m) << 12);
      cyc(3);
      check({drv.pull_up, drv.pull_down, drv.oe}, exp[m]);
    end
    ext_en <= 1'b1;
    ext_val <= 1'b1;
    cyc(6);
    check(in_direct, 1'b1);
  endtask

  //////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_config();
    t_regs();
    t_preset();
    t_invert();
    t_disable();
    t_latch();
    t_unused();
    close_out();
  end
endmodule
`default_nettype wire
